// *** include/cmpc_defs.svh ***
`ifndef CMPC_DEFS_SVH
`define CMPC_DEFS_SVH

// ----------------------------------------------------------------
// Register map (byte addresses on the plain register port)
// ----------------------------------------------------------------
`define CMPC_ADDR_W 8
`define CMPC_DATA_W 8
`define CMPC_CH_STRIDE 8'h04
`define CMPC_OFF_CTRL_FIRST 2'h0
`define CMPC_OFF_CTRL_SECOND 2'h1
`define CMPC_OFF_MINUS_SEL 2'h2
`define CMPC_OFF_PLUS_SEL 2'h3
`define CMPC_ADDR_CH_LAST 8'h07
`define CMPC_ADDR_MIRROR 8'h08
`define CMPC_ADDR_IRQ_FLAG 8'h09
`define CMPC_ADDR_WAKE_EN 8'h0a
`define CMPC_ADDR_ANALOG_SEL 8'h0b
`define CMPC_ADDR_PORT 8'h0c

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CMPC_BIT_ENABLE 7
`define CMPC_BIT_RESULT 6
`define CMPC_BIT_INVERT 4
`define CMPC_BIT_HYST 1
`define CMPC_BIT_ALIGN 0
`define CMPC_BIT_RISE 1
`define CMPC_BIT_FALL 0

// ----------------------------------------------------------------
// Input select encodings and reset values
// ----------------------------------------------------------------
`define CMPC_PLUS_OPEN_A 3'h2
`define CMPC_PLUS_OPEN_B 3'h3
`define CMPC_PLUS_DISPLAY_REF 3'h4
`define CMPC_MINUS_OPEN 3'h5
`define CMPC_RESET_BYTE 8'h00

// ----------------------------------------------------------------
// Timing: instruction cycle is four core cycles
// ----------------------------------------------------------------
`define CMPC_INSTR_LAST 2'h3

`endif

// *** include/cmpc_pkg.sv ***
package cmpc_pkg;

    typedef struct packed {
        logic en;
        logic inv;
        logic hyst;
        logic align;
        logic riseEn;
        logic fallEn;
        logic [2:0] plusSel;
        logic [2:0] minusSel;
    } cmpc_cfg_t;

    typedef struct packed {
        logic powerOn;
        logic hyst;
        logic plusConnect;
        logic [2:0] plusCode;
        logic minusConnect;
        logic [2:0] minusCode;
    } cmpc_ana_t;

endpackage

// *** hdl/cmpc_top.sv ***
`timescale 1ns/1ns
`include "cmpc_defs.svh"

// Notes on behaviour
// - Comparator runs only while enabled
// - Result readable in control and mirror
// - Internal result latched once per instruction
// - Invert bit complements plus-over-minus result
// - Hysteresis bit adds input separation voltage
// - Result offered as gate timer gate
// - Aligned result taken on timer falling edge
// - Prescaled timer clock used when prescaling
// - Qualified rise or fall sets flag
// - Software clears flag; new edge wins
// - Invert or enable toggles reach edge detectors
// - Three-bit plus select picks plus source
// - Disabled comparator disconnects all inputs
// - Three-bit minus select picks minus source
// - Analog-selected port pins read as zero
// - Active result with enable suspends waveform
// - Unaligned comparator keeps running in Sleep
// - Aligned path on system clock stops asleep
// - Enabled comparator interrupt wakes from Sleep
// - Plus select encoding table
// - Minus select encoding table
// - Unaligned result passes without timer edge
module cmpc_top (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdData,
    input wire logic [1:0] cmpRaw,
    output cmpc_pkg::cmpc_ana_t [1:0] anaCtrl,
    input wire logic tmrSrcClk,
    input wire logic tmrPrescaledClk,
    input wire logic tmrPrescaleOn,
    input wire logic tmrClkIsSys,
    input wire logic sleepMode,
    output logic [1:0] gateOut,
    input wire logic [1:0] shutdownSrcEnable,
    output logic waveSuspend,
    output logic [1:0] irqReq,
    output logic wakeReq,
    input wire logic [7:0] portPins
);
    import cmpc_pkg::*;

    // ------------------------------------------------------------
    // Instruction-cycle divider
    // ------------------------------------------------------------
    logic [1:0] instrCnt;
    logic instrTick;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            instrCnt <= 2'h0;
        end else begin
            instrCnt <= instrCnt + 2'h1;
        end
    end

    assign instrTick = (instrCnt == `CMPC_INSTR_LAST);

    // ------------------------------------------------------------
    // Synchronisers for the analog outputs, timer clocks and pins
    // ------------------------------------------------------------
    logic [1:0] rawS1;
    logic [1:0] rawS2;
    logic srcS1;
    logic srcS2;
    logic preS1;
    logic preS2;
    logic tmrPrev;
    logic tmrCur;
    logic tmrFall;
    logic [7:0] pinS1;
    logic [7:0] pinS2;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rawS1 <= 2'h0;
            rawS2 <= 2'h0;
        end else begin
            rawS1 <= cmpRaw;
            rawS2 <= rawS1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            srcS1 <= 1'b0;
            srcS2 <= 1'b0;
            preS1 <= 1'b0;
            preS2 <= 1'b0;
            tmrPrev <= 1'b0;
        end else begin
            srcS1 <= tmrSrcClk;
            srcS2 <= srcS1;
            preS1 <= tmrPrescaledClk;
            preS2 <= preS1;
            tmrPrev <= tmrCur;
        end
    end

    assign tmrCur = tmrPrescaleOn ? preS2 : srcS2;
    // Falling edge so the timer, counting on rising, never races us
    assign tmrFall = tmrPrev & ~tmrCur;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pinS1 <= 8'h00;
            pinS2 <= 8'h00;
        end else begin
            pinS1 <= portPins;
            pinS2 <= pinS1;
        end
    end

    // ------------------------------------------------------------
    // Shared registers
    // ------------------------------------------------------------
    logic [1:0] irqFlag;
    logic [1:0] wakeEn;
    logic [7:0] analogSel;
    logic [1:0] latched;
    logic [1:0] setEvt;
    logic wrFlag;

    assign wrFlag = regWr && (regAddr == `CMPC_ADDR_IRQ_FLAG);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wakeEn <= 2'h0;
        end else if (regWr && (regAddr == `CMPC_ADDR_WAKE_EN)) begin
            wakeEn <= regWrData[1:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            analogSel <= `CMPC_RESET_BYTE;
        end else if (regWr && (regAddr == `CMPC_ADDR_ANALOG_SEL)) begin
            analogSel <= regWrData;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            irqFlag <= 2'h0;
        end else begin
            irqFlag <= setEvt | (wrFlag ? regWrData[1:0] : irqFlag);
        end
    end

    // ------------------------------------------------------------
    // Per-channel logic
    // ------------------------------------------------------------
    cmpc_cfg_t [1:0] cfg;
    logic [1:0] res;
    logic [1:0] alignedQ;
    logic [1:0] alignHold;
    logic [1:0][7:0] chRd [0:3];

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
            logic hit;
            logic [1:0] off;

            assign hit = (regAddr[7:2] == 6'(ch));
            assign off = regAddr[1:0];

            always_ff @(posedge core_clk) begin
                if (!rst_n) begin
                    cfg[ch] <= '0;
                end else if (regWr && hit) begin
                    case (off)
                        `CMPC_OFF_CTRL_FIRST: begin
                            cfg[ch].en <= regWrData[`CMPC_BIT_ENABLE];
                            cfg[ch].inv <= regWrData[`CMPC_BIT_INVERT];
                            cfg[ch].hyst <= regWrData[`CMPC_BIT_HYST];
                            cfg[ch].align <= regWrData[`CMPC_BIT_ALIGN];
                        end
                        `CMPC_OFF_CTRL_SECOND: begin
                            cfg[ch].riseEn <= regWrData[`CMPC_BIT_RISE];
                            cfg[ch].fallEn <= regWrData[`CMPC_BIT_FALL];
                        end
                        `CMPC_OFF_MINUS_SEL: begin
                            cfg[ch].minusSel <= regWrData[2:0];
                        end
                        default: begin
                            cfg[ch].plusSel <= regWrData[2:0];
                        end
                    endcase
                end
            end

            // disabled reads as low before polarity
            // so toggling invert or enable still moves the result
            assign res[ch] = (cfg[ch].en & rawS2[ch]) ^ cfg[ch].inv;

            always_ff @(posedge core_clk) begin
                if (!rst_n) begin
                    latched[ch] <= 1'b0;
                end else if (instrTick) begin
                    latched[ch] <= res[ch];
                end
            end

            // qualified edges of the latched result
            assign setEvt[ch] = instrTick &&
                ((cfg[ch].riseEn && res[ch] && !latched[ch]) ||
                 (cfg[ch].fallEn && !res[ch] && latched[ch]));

            // timer stops in Sleep when fed from system clock
            assign alignHold[ch] = sleepMode && tmrClkIsSys;

            always_ff @(posedge core_clk) begin
                if (!rst_n) begin
                    alignedQ[ch] <= 1'b0;
                end else if (tmrFall && !alignHold[ch]) begin
                    alignedQ[ch] <= res[ch];
                end
            end

            assign gateOut[ch] = cfg[ch].align ? alignedQ[ch] : res[ch];

            always_comb begin
                anaCtrl[ch].powerOn = cfg[ch].en;
                anaCtrl[ch].hyst = cfg[ch].en & cfg[ch].hyst;
                anaCtrl[ch].plusCode = cfg[ch].plusSel;
                anaCtrl[ch].minusCode = cfg[ch].minusSel;
                anaCtrl[ch].plusConnect = cfg[ch].en &&
                    (cfg[ch].plusSel != `CMPC_PLUS_OPEN_A) &&
                    (cfg[ch].plusSel != `CMPC_PLUS_OPEN_B) &&
                    !(ch == 0 &&
                      cfg[ch].plusSel == `CMPC_PLUS_DISPLAY_REF);
                anaCtrl[ch].minusConnect = cfg[ch].en &&
                    (cfg[ch].minusSel != `CMPC_MINUS_OPEN);
            end

            // status byte shows the latched result
            always_comb begin
                chRd[0][ch] = 8'h00;
                chRd[0][ch][`CMPC_BIT_ENABLE] = cfg[ch].en;
                chRd[0][ch][`CMPC_BIT_RESULT] = latched[ch];
                chRd[0][ch][`CMPC_BIT_INVERT] = cfg[ch].inv;
                chRd[0][ch][`CMPC_BIT_HYST] = cfg[ch].hyst;
                chRd[0][ch][`CMPC_BIT_ALIGN] = cfg[ch].align;
                chRd[1][ch] = 8'h00;
                chRd[1][ch][`CMPC_BIT_RISE] = cfg[ch].riseEn;
                chRd[1][ch][`CMPC_BIT_FALL] = cfg[ch].fallEn;
                chRd[2][ch] = {5'h00, cfg[ch].minusSel};
                chRd[3][ch] = {5'h00, cfg[ch].plusSel};
            end

            // ----------------------------------------------------
            // Checks for this channel
            // ----------------------------------------------------
            property p_latch_tick;
                @(posedge core_clk) disable iff (!rst_n)
                instrTick |=> latched[ch] == $past(res[ch]);
            endproperty
            a_latch_tick: assert property (p_latch_tick)
                else $error("latch missed instruction tick");

            property p_latch_hold;
                @(posedge core_clk) disable iff (!rst_n)
                !instrTick |=> $stable(latched[ch]);
            endproperty
            a_latch_hold: assert property (p_latch_hold)
                else $error("latch moved between ticks");

            property p_polarity;
                @(posedge core_clk) disable iff (!rst_n)
                cfg[ch].en |-> res[ch] == (rawS2[ch] ^ cfg[ch].inv);
            endproperty
            a_polarity: assert property (p_polarity)
                else $error("polarity wrong");

            property p_flag_set;
                @(posedge core_clk) disable iff (!rst_n)
                (instrTick && cfg[ch].riseEn && res[ch] && !latched[ch])
                |=> irqFlag[ch];
            endproperty
            a_flag_set: assert property (p_flag_set)
                else $error("rising edge did not set flag");

            property p_set_wins;
                @(posedge core_clk) disable iff (!rst_n)
                (setEvt[ch] && wrFlag && !regWrData[ch]) |=> irqFlag[ch];
            endproperty
            a_set_wins: assert property (p_set_wins)
                else $error("clear beat a new edge");

            property p_disconnect;
                @(posedge core_clk) disable iff (!rst_n)
                !cfg[ch].en |-> !anaCtrl[ch].plusConnect &&
                    !anaCtrl[ch].minusConnect && !anaCtrl[ch].powerOn;
            endproperty
            a_disconnect: assert property (p_disconnect)
                else $error("disabled comparator still connected");

            property p_align_fall;
                @(posedge core_clk) disable iff (!rst_n)
                (tmrFall && !alignHold[ch])
                |=> alignedQ[ch] == $past(res[ch]);
            endproperty
            a_align_fall: assert property (p_align_fall)
                else $error("aligned result not taken on fall");

            property p_sleep_hold;
                @(posedge core_clk) disable iff (!rst_n)
                (sleepMode && tmrClkIsSys)[*2] |-> $stable(alignedQ[ch]);
            endproperty
            a_sleep_hold: assert property (p_sleep_hold)
                else $error("aligned path moved in Sleep");

            property p_async;
                @(posedge core_clk) disable iff (!rst_n)
                !cfg[ch].align |-> gateOut[ch] == res[ch];
            endproperty
            a_async: assert property (p_async)
                else $error("unaligned gate not direct");
        end
    endgenerate

    // ------------------------------------------------------------
    // Waveform shutdown, interrupt and wake outputs
    // ------------------------------------------------------------
    // immediate suspend, no latch in the way
    assign waveSuspend = |(res & shutdownSrcEnable);
    assign irqReq = irqFlag;
    assign wakeReq = |(irqFlag & wakeEn);

    property p_shutdown;
        @(posedge core_clk) disable iff (!rst_n)
        (res[1] && shutdownSrcEnable[1]) |-> waveSuspend;
    endproperty
    a_shutdown: assert property (p_shutdown)
        else $error("shutdown not raised");

    property p_wake;
        @(posedge core_clk) disable iff (!rst_n)
        (|(setEvt & wakeEn) && !regWr) |=> wakeReq;
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake not raised");

    // ------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------
    logic [7:0] next_regRdData;

    always_comb begin
        next_regRdData = 8'h00;
        if (regAddr <= `CMPC_ADDR_CH_LAST) begin
            next_regRdData = chRd[regAddr[1:0]][regAddr[2]];
        end else begin
            case (regAddr)
                `CMPC_ADDR_MIRROR: next_regRdData = {6'h00, latched};
                `CMPC_ADDR_IRQ_FLAG: next_regRdData = {6'h00, irqFlag};
                `CMPC_ADDR_WAKE_EN: next_regRdData = {6'h00, wakeEn};
                `CMPC_ADDR_ANALOG_SEL: next_regRdData = analogSel;
                `CMPC_ADDR_PORT: next_regRdData = pinS2 & ~analogSel;
                default: next_regRdData = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            regRdData <= 8'h00;
        end else begin
            regRdData <= regRd ? next_regRdData : 8'h00;
        end
    end

    property p_mirror;
        @(posedge core_clk) disable iff (!rst_n)
        (regRd && regAddr == `CMPC_ADDR_MIRROR)
        |=> regRdData == {6'h00, $past(latched)};
    endproperty
    a_mirror: assert property (p_mirror)
        else $error("mirror read wrong");

endmodule

// *** test/cmpc_far_model.sv ***
`timescale 1ns/1ns
// ------------------------------------------------------------
// Far side: gate timer clocks and waveform shutdown enables
// ------------------------------------------------------------
module cmpc_far_model (
    input wire logic core_clk,
    input wire logic runSrc,
    input wire logic runPre,
    input wire logic [1:0] shutEn,
    output logic tmrSrcClk,
    output logic tmrPrescaledClk,
    output logic [1:0] shutdownSrcEnable
);
    logic [1:0] srcDiv = 2'h0;
    logic [2:0] preDiv = 3'h0;

    initial begin
        tmrSrcClk = 1'b0;
        tmrPrescaledClk = 1'b0;
    end

    // timer clock source
    // Clocks stand still while stopped, so no stray falling edge
    always @(posedge core_clk) begin
        if (runSrc) begin
            srcDiv <= srcDiv + 2'h1;
            if (srcDiv == 2'h3) tmrSrcClk <= ~tmrSrcClk;
        end
    end

    always @(posedge core_clk) begin
        if (runPre) begin
            preDiv <= preDiv + 3'h1;
            if (preDiv == 3'h7) tmrPrescaledClk <= ~tmrPrescaledClk;
        end
    end

    assign shutdownSrcEnable = shutEn;
endmodule

// *** test/cmpc_top_tb_top.sv ***
`timescale 1ns/1ns
module cmpc_top_tb_top;
    import cmpc_pkg::*;

    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [7:0] regRdData;
    logic [1:0] cmpRaw = 2'h0;
    cmpc_ana_t [1:0] anaCtrl;
    logic tmrSrcClk;
    logic tmrPrescaledClk;
    logic tmrPrescaleOn = 1'b0;
    logic tmrClkIsSys = 1'b0;
    logic sleepMode = 1'b0;
    logic [1:0] gateOut;
    logic [1:0] shutdownSrcEnable;
    logic waveSuspend;
    logic [1:0] irqReq;
    logic wakeReq;
    logic [7:0] portPins = 8'h00;
    logic runSrc = 1'b0;
    logic runPre = 1'b0;
    logic [1:0] shutEn = 2'h0;
    int failures = 0;
    int n_checks = 0;

    cmpc_top uut (.core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .cmpRaw(cmpRaw), .anaCtrl(anaCtrl),
        .tmrSrcClk(tmrSrcClk), .tmrPrescaledClk(tmrPrescaledClk),
        .tmrPrescaleOn(tmrPrescaleOn), .tmrClkIsSys(tmrClkIsSys),
        .sleepMode(sleepMode), .gateOut(gateOut),
        .shutdownSrcEnable(shutdownSrcEnable), .waveSuspend(waveSuspend),
        .irqReq(irqReq), .wakeReq(wakeReq), .portPins(portPins));

    cmpc_far_model far (.core_clk(core_clk), .runSrc(runSrc),
        .runPre(runPre), .shutEn(shutEn), .tmrSrcClk(tmrSrcClk),
        .tmrPrescaledClk(tmrPrescaledClk),
        .shutdownSrcEnable(shutdownSrcEnable));

    initial begin
        forever #5 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        if (failures == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge core_clk);
        regWr <= 1'b0;
        #1;
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1;
        chk(regRdData, exp);
    endtask

    // Covers two syncs, an instruction tick and the flag edge
    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        chk(anaCtrl[0][9:2], 8'h00);
        chk(anaCtrl[1][9:2], 8'h00);
        chk({anaCtrl[0][1:0], anaCtrl[1][1:0], gateOut, irqReq},
            8'h00);
        chk({6'h00, wakeReq, waveSuspend}, 8'h00);
        for (int a = 0; a < 14; a++) begin
            rdChk(a[7:0], 8'h00);
        end
        wr(8'h0d, 8'hff);
        rdChk(8'h0d, 8'h00);
    endtask

    task automatic t_select();
        logic pc;
        for (int ch = 0; ch < 2; ch++) begin
            wr(8'(4 * ch), 8'h82);
            chk({anaCtrl[ch].powerOn, anaCtrl[ch].hyst}, 8'h03);
            for (int c = 0; c < 8; c++) begin
                wr(8'(4 * ch + 3), 8'(c));
                wr(8'(4 * ch + 2), 8'(c));
                pc = !(c == 2 || c == 3 || (c == 4 && ch == 0));
                chk(anaCtrl[ch].plusConnect, pc);
                chk(anaCtrl[ch].minusConnect, c != 5);
                if (pc) chk(anaCtrl[ch].plusCode, 8'(c));
                if (c != 5) chk(anaCtrl[ch].minusCode, 8'(c));
            end
            wr(8'(4 * ch), 8'h02);
            // Select codes may stay; only power, hysteresis and connections drop
            chk({anaCtrl[ch].powerOn, anaCtrl[ch].hyst,
                anaCtrl[ch].plusConnect, anaCtrl[ch].minusConnect},
                8'h00);
            wr(8'(4 * ch + 3), 8'h00);
            wr(8'(4 * ch + 2), 8'h00);
        end
    endtask

    task automatic t_result();
        cmpRaw <= 2'b11;
        wr(8'h00, 8'h80);
        wr(8'h04, 8'h90);
        settle(10);
        rdChk(8'h00, 8'hc0);
        rdChk(8'h04, 8'h90);
        rdChk(8'h08, 8'h01);
        // gateOut is what a routed, output-enabled pin carries
        chk(gateOut, 2'b01);
        shutEn <= 2'b10;
        settle(1);
        chk(waveSuspend, 1'b0);
        cmpRaw <= 2'b00;
        settle(10);
        rdChk(8'h08, 8'h02);
        chk({gateOut, waveSuspend}, 8'h05);
        shutEn <= 2'b00;
        wr(8'h00, 8'h00);
        wr(8'h04, 8'h00);
    endtask

    task automatic t_irq();
        settle(10);
        wr(8'h09, 8'h00);
        wr(8'h01, 8'h02);
        wr(8'h00, 8'h10);
        settle(10);
        rdChk(8'h09, 8'h01);
        chk(irqReq, 2'b01);
        chk(wakeReq, 1'b0);
        wr(8'h0a, 8'h01);
        chk(wakeReq, 1'b1);
        wr(8'h09, 8'h00);
        chk(irqReq, 2'b00);
        wr(8'h00, 8'h00);
        settle(10);
        chk(irqReq, 2'b00);
        wr(8'h01, 8'h01);
        wr(8'h00, 8'h10);
        // Hold the rise past an instruction tick so it gets latched
        settle(4);
        wr(8'h00, 8'h00);
        settle(10);
        chk(irqReq, 2'b01);
        chk(wakeReq, 1'b1);
        wr(8'h09, 8'h00);
        wr(8'h0a, 8'h00);
        wr(8'h01, 8'h00);
    endtask

    task automatic t_port();
        portPins <= 8'ha5;
        wr(8'h0b, 8'h0f);
        settle(4);
        rdChk(8'h0c, 8'ha0);
        wr(8'h0b, 8'h00);
        rdChk(8'h0c, 8'ha5);
    endtask

    task automatic t_align();
        // result gates the timer, so align it
        wr(8'h00, 8'h81);
        runSrc <= 1'b1;
        settle(24);
        chk(gateOut[0], 1'b0);
        runSrc <= 1'b0;
        // Let a fall already in the synchronisers land first
        settle(4);
        cmpRaw <= 2'b01;
        settle(24);
        chk(gateOut[0], 1'b0);
        runSrc <= 1'b1;
        settle(24);
        chk(gateOut[0], 1'b1);
        tmrPrescaleOn <= 1'b1;
        cmpRaw <= 2'b00;
        settle(40);
        chk(gateOut[0], 1'b1);
        runPre <= 1'b1;
        settle(40);
        chk(gateOut[0], 1'b0);
        tmrClkIsSys <= 1'b1;
        sleepMode <= 1'b1;
        cmpRaw <= 2'b01;
        settle(40);
        chk(gateOut[0], 1'b0);
        wr(8'h00, 8'h80);
        settle(4);
        chk(gateOut[0], 1'b1);
        sleepMode <= 1'b0;
        runSrc <= 1'b0;
        runPre <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // Main sequence and hang guard
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        #1;
        t_reset();
        t_select();
        t_result();
        t_irq();
        t_port();
        t_align();
        close_out();
    end

    initial begin
        repeat (100000) @(posedge core_clk);
        failures++;
        close_out();
    end
endmodule
